// ---- rtccs_pkg.sv ----
// Package of the RTC control, status and interrupt block.
// Assumes a 20 MHz reference clock and an 8-bit register port with
// four-bit addresses.
package rtccs_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam logic [3:0] ADDR_ADJUST = 4'h7;
	localparam logic [3:0] ADDR_CTRL_A = 4'he;
	localparam logic [3:0] ADDR_CTRL_B = 4'hf;

	// Control A field positions
	localparam int CA_WEEKLY_ALARM_ENABLE   = 7;
	localparam int CA_DAILY_ALARM_ENABLE   = 6;
	localparam int CA_H24    = 5;
	localparam int CA_SPAREC = 4;
	localparam int CA_TEST   = 3;
	localparam int CA_CT_LSB = 0;

	// Status/control B field positions
	localparam int CB_SUPPLY_THRESHOLD_SELECT   = 7;
	localparam int CB_SUPPLY_LOW_FLAG   = 6;
	localparam int CB_SPAREA = 5;
	localparam int CB_HALT   = 4;
	localparam int CB_SPAREB = 3;
	localparam int CB_PERIODIC_IRQ_FLAG   = 2;
	localparam int CB_WEEKLY_ALARM_FLAG   = 1;
	localparam int CB_DAILY_ALARM_FLAG   = 0;

	// Reset values
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [7:0] CTRL_B_RST = 8'h10;
	localparam logic [6:0] ADJ_RST    = 7'h00;

	// Periodic select encodings
	localparam logic [2:0] CT_OFF   = 3'h0;
	localparam logic [2:0] CT_LOW   = 3'h1;
	localparam logic [2:0] CT_2HZ   = 3'h2;
	localparam logic [2:0] CT_1HZ   = 3'h3;
	localparam logic [2:0] CT_SEC   = 3'h4;
	localparam logic [2:0] CT_MIN   = 3'h5;
	localparam logic [2:0] CT_HOUR  = 3'h6;
	localparam logic [2:0] CT_MONTH = 3'h7;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_PERIOD_NS   = 50;
	localparam int SEC_DELAY_NS    = 92000;
	localparam int SEC_DELAY_CYC   = (SEC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ALARM_DELAY_NS  = 61000;
	localparam int ALARM_DELAY_CYC = (ALARM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QUARTER_NS      = 250000000;
	localparam int QUARTER_CYC     = QUARTER_NS / CLK_PERIOD_NS;
	localparam int ADJ_MAX_NS      = 3784000;
	localparam int ADJ_STEPS       = 63;
	localparam int ADJ_UNIT_CYC    = ADJ_MAX_NS / ADJ_STEPS / CLK_PERIOD_NS;
	localparam int ADJ_PERIOD_SEC  = 20;

	// ********************************
	// Carriers
	// ********************************
	typedef struct packed {
		logic       wr;
		logic [3:0] addr;
		logic [7:0] data;
	} rtccs_wr_t;

	// Calendar state that the coming seconds increment produces
	typedef struct packed {
		logic sec_zero;
		logic min_zero;
		logic hour_zero;
		logic day_one;
	} rtccs_cal_t;

endpackage

// ---- rtccs_core.sv ----
// Control, status and interrupt logic of a two-wire RTC.
// Assumes a protocol engine delivering register writes and read addresses
// on the reference clock, and calendar counters fed by o_sec_inc.
//
// Overview of operation
// - Three spare bits read and write freely, cleared when halt flag sets.
// - Periodic select: off, low, 2Hz, 1Hz, then second/minute/hour/month level.
// - Pulse mode toggles at 50% duty, aligned to seconds increment.
// - Level mode output falls exactly when seconds counter increments.
// - Minute, hour, month levels fire at :00, 00:00, and 00:00:00 day one.
// - Adjustment stretches or shrinks one low quarter every 20 s, at most 3.784 ms.
// - Seconds increment follows pulse falling edge by about 92 us.
// - Writing seconds clears sub-second divider; in pulse modes this drives periodic output low.
// - Threshold select: 0 picks 2.1 V, 1 picks 1.6 V, reset 0.
// - Supply-low flag sets below threshold, then monitoring stops, flag holds.
// - Writing 0 clears supply-low flag and restarts monitoring; 1 ignored.
// - Halt flag sets when oscillator stops and holds after it resumes.
// - While halt flag is 1, adjust and control registers clear, interrupts stop.
// - Writing 0 clears halt flag and re-arms detection; 1 ignored.
// - Periodic flag reads 1 while generator drives primary output low.
// - In level mode writing 0 to periodic flag releases output till next interval.
// - Alarm flag sets about 61 us after an enabled match.
// - Writing 0 to an alarm flag clears it and releases its output.
// - Alarm flag reads 0 while its enable bit is 0.
// - Alarm enable gates matching; reset value 0.
`timescale 1ns/1ps

module rtccs_core
	import rtccs_pkg::*;
#(
	parameter int QUARTER_LEN = QUARTER_CYC
) (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_nrst,
	// Register port
	input  wire rtccs_wr_t  i_reg_wr,
	input  wire logic [3:0] i_reg_raddr,
	output logic      [7:0] o_reg_rdata,
	// Timekeeping
	input  wire logic       i_sec_write,
	input  wire rtccs_cal_t i_cal_next,
	input  wire logic       i_weekly_alarm_match,
	input  wire logic       i_daily_alarm_match,
	output logic            o_sec_inc,
	// Analog sense pins
	input  wire logic       i_osc_stopped,
	input  wire logic       i_supply_below_2v1,
	input  wire logic       i_supply_below_1v6,
	// Settings for the rest of the device
	output logic            o_hour24_mode,
	output logic            o_test_mode,
	output logic      [6:0] o_adjust,
	output logic            o_supply_threshold_select,
	// Open-drain interrupt pins
	output logic            o_irq_out_primary,
	output logic            o_irq_out_primary_oe,
	output logic            o_irq_out_secondary,
	output logic            o_irq_out_secondary_oe
);

	localparam logic [23:0] QLEN      = 24'(QUARTER_LEN);
	localparam logic [23:0] SEC_DLY   = 24'(SEC_DELAY_CYC);
	localparam logic [10:0] ALARM_DLY = 11'(ALARM_DELAY_CYC);
	localparam logic [10:0] ADJ_UNIT  = 11'(ADJ_UNIT_CYC);
	localparam logic [4:0]  ADJ_LAST  = 5'(ADJ_PERIOD_SEC - 1);

	// ********************************
	// Declarations
	// ********************************
	logic [2:0]  sync1_reg;
	logic [2:0]  sync2_reg;
	logic        halt_reg;
	logic [1:0]  alarm_en_reg;
	logic [1:0]  alarm_flag_reg;
	logic [1:0]  alarm_busy_reg;
	logic [10:0] alarm_dly_reg [2];
	logic        hour24_reg;
	logic        test_reg;
	logic [2:0]  ct_reg;
	logic [2:0]  spare_reg;
	logic        supply_threshold_select_reg;
	logic        supply_low_flag_reg;
	logic        lvl_reg;
	logic [6:0]  adj_reg;
	logic [23:0] qcnt_reg;
	logic [1:0]  q_reg;
	logic [4:0]  sec20_reg;
	logic        sec_inc_reg;
	logic        sec_inc_d_reg;
	logic        irq_a_reg;
	logic        irq_b_reg;
	logic [7:0]  rdata_reg;

	// ********************************
	// Decode
	// ********************************
	// Register write strobes and flag clears
	wire         wr_adj     = i_reg_wr.wr && (i_reg_wr.addr == ADDR_ADJUST);
	wire         wr_a       = i_reg_wr.wr && (i_reg_wr.addr == ADDR_CTRL_A);
	wire         wr_b       = i_reg_wr.wr && (i_reg_wr.addr == ADDR_CTRL_B);
	wire [7:0]   wd         = i_reg_wr.data;
	wire         halt_clr   = wr_b && !wd[CB_HALT];
	wire         supply_low_flag_clr   = wr_b && !wd[CB_SUPPLY_LOW_FLAG];
	wire         periodic_irq_flag_clr   = wr_b && !wd[CB_PERIODIC_IRQ_FLAG];
	wire [1:0]   alarm_clr  = {wr_b && !wd[CB_WEEKLY_ALARM_FLAG], wr_b && !wd[CB_DAILY_ALARM_FLAG]};
	wire [1:0]   alarm_hit  = {i_weekly_alarm_match, i_daily_alarm_match};
	wire [1:0]   alarm_en_w = {wd[CA_WEEKLY_ALARM_ENABLE], wd[CA_DAILY_ALARM_ENABLE]};

	// Synchronised sense levels
	wire         osc_stop   = sync2_reg[0];
	wire         below_sel  = supply_threshold_select_reg ? sync2_reg[2] : sync2_reg[1];

	// Quarter length with the 20 s adjustment window
	wire [16:0]  adj_delta  = 17'(adj_reg[5:0] * ADJ_UNIT);
	wire         stretch    = (q_reg == 2'h0) && (sec20_reg == 5'h0) && (adj_reg[5:0] != 6'h0);
	wire [23:0]  qlen_up    = QLEN + 24'(adj_delta);
	wire [23:0]  qlen_dn    = QLEN - 24'(adj_delta);
	wire [23:0]  qlen       = !stretch ? QLEN : (adj_reg[6] ? qlen_dn : qlen_up);
	wire         qwrap      = qcnt_reg == qlen - 24'h1;

	// Seconds increment sits a fixed delay after the start of quarter 0
	wire         sec_inc_w  = (q_reg == 2'h0) && (qcnt_reg == SEC_DLY - 24'h1);

	// Level-mode interval match
	wire         ival_hit   = (ct_reg == CT_SEC)
	                       || (ct_reg == CT_MIN && i_cal_next.sec_zero)
	                       || (ct_reg == CT_HOUR && i_cal_next.sec_zero && i_cal_next.min_zero)
	                       || (ct_reg == CT_MONTH && i_cal_next.sec_zero && i_cal_next.min_zero
	                           && i_cal_next.hour_zero && i_cal_next.day_one);
	wire         lvl_set    = sec_inc_w && ct_reg[2] && ival_hit;

	// Periodic output state; pulse modes are low in the first half of each period
	wire         pulse_low  = (ct_reg == CT_2HZ) ? !q_reg[0] : ((ct_reg == CT_1HZ) && !q_reg[1]);
	wire         per_low    = (ct_reg == CT_LOW) || pulse_low || (ct_reg[2] && lvl_reg);

	// Read views
	wire [7:0]   ctrl_a_rd  = {alarm_en_reg, hour24_reg, spare_reg[2], test_reg, ct_reg};
	wire [7:0]   ctrl_b_rd  = {supply_threshold_select_reg, supply_low_flag_reg, spare_reg[0], halt_reg, spare_reg[1], per_low,
	                           alarm_flag_reg & alarm_en_reg};
	wire [7:0]   rd_next    = (i_reg_raddr == ADDR_ADJUST) ? {1'b0, adj_reg}
	                        : (i_reg_raddr == ADDR_CTRL_A) ? ctrl_a_rd
	                        : (i_reg_raddr == ADDR_CTRL_B) ? ctrl_b_rd : 8'h00;

	// ********************************
	// Sense synchronisers and halt flag
	// ********************************
	// Two flops on each analog sense pin
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {i_supply_below_1v6, i_supply_below_2v1, i_osc_stopped};
			sync2_reg <= sync1_reg;
		end
	end

	// Halt flag: powers up set, sticky, cleared only by a 0 write
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst)
			halt_reg <= CTRL_B_RST[CB_HALT];
		else
			halt_reg <= osc_stop || (halt_reg && !halt_clr);
	end

	// ********************************
	// Control registers
	// ********************************
	// Everything but the halt flag is held at zero while the halt flag is set
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst || halt_reg) begin
			{alarm_en_reg, hour24_reg, spare_reg[2], test_reg, ct_reg} <= CTRL_A_RST;
			{supply_threshold_select_reg, spare_reg[0], spare_reg[1]} <= 3'h0;
			adj_reg <= ADJ_RST;
		end else begin
			if (wr_a) begin
				{alarm_en_reg, hour24_reg, spare_reg[2], test_reg, ct_reg} <= wd;
			end
			if (wr_b) begin
				supply_threshold_select_reg     <= wd[CB_SUPPLY_THRESHOLD_SELECT];
				spare_reg[0] <= wd[CB_SPAREA];
				spare_reg[1] <= wd[CB_SPAREB];
			end
			if (wr_adj)
				adj_reg <= wd[6:0];
		end
	end

	// Supply-low flag: once set it holds and monitoring pauses until cleared
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst || halt_reg)
			supply_low_flag_reg <= CTRL_B_RST[CB_SUPPLY_LOW_FLAG];
		else
			supply_low_flag_reg <= below_sel || (supply_low_flag_reg && !supply_low_flag_clr);
	end

	// ********************************
	// Periodic generator
	// ********************************
	// Quarter-second divider; a seconds write restarts it in quarter 0
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst || i_sec_write) begin
			qcnt_reg <= 24'h0;
			q_reg    <= 2'h0;
		end else if (qwrap) begin
			qcnt_reg <= 24'h0;
			q_reg    <= q_reg + 2'h1;
		end else begin
			qcnt_reg <= qcnt_reg + 24'h1;
		end
	end

	// Seconds within the adjustment period, and the delayed increment pulse
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			sec20_reg     <= 5'h0;
			sec_inc_reg   <= 1'b0;
			sec_inc_d_reg <= 1'b0;
		end else begin
			if (sec_inc_w)
				sec20_reg <= (sec20_reg == ADJ_LAST) ? 5'h0 : sec20_reg + 5'h1;
			sec_inc_reg   <= sec_inc_w;
			sec_inc_d_reg <= sec_inc_reg;
		end
	end

	// Level-mode latch; a set in the same cycle as a clear wins
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst || halt_reg || !ct_reg[2])
			lvl_reg <= 1'b0;
		else
			lvl_reg <= lvl_set || (lvl_reg && !periodic_irq_flag_clr);
	end

	// ********************************
	// Alarm flags
	// ********************************
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_alarm
			wire fire = alarm_busy_reg[gi] && (alarm_dly_reg[gi] == ALARM_DLY - 11'h1);

			// Delay from match to flag, then a sticky flag that reads 0 while disabled
			always_ff @(posedge i_ref_clk) begin
				if (!i_nrst || !alarm_en_reg[gi]) begin
					alarm_busy_reg[gi] <= 1'b0;
					alarm_dly_reg[gi]  <= 11'h0;
					alarm_flag_reg[gi] <= 1'b0;
				end else begin
					if (alarm_hit[gi]) begin
						alarm_busy_reg[gi] <= 1'b1;
						alarm_dly_reg[gi]  <= 11'h0;
					end else if (fire) begin
						alarm_busy_reg[gi] <= 1'b0;
					end else if (alarm_busy_reg[gi]) begin
						alarm_dly_reg[gi] <= alarm_dly_reg[gi] + 11'h1;
					end
					alarm_flag_reg[gi] <= fire || (alarm_flag_reg[gi] && !alarm_clr[gi]);
				end
			end
		end
	endgenerate

	// ********************************
	// Outputs
	// ********************************
	// Pin drivers and read data; in level mode the primary pin falls with the delayed increment pulse
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			irq_a_reg <= 1'b0;
			irq_b_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			irq_a_reg <= !halt_reg && (per_low || alarm_flag_reg[1]);
			irq_b_reg <= !halt_reg && alarm_flag_reg[0];
			rdata_reg <= rd_next;
		end
	end

	assign o_reg_rdata               = rdata_reg;
	assign o_sec_inc                 = sec_inc_d_reg;
	assign o_hour24_mode             = hour24_reg;
	assign o_test_mode               = test_reg;
	assign o_adjust                  = adj_reg;
	assign o_supply_threshold_select = supply_threshold_select_reg;
	assign o_irq_out_primary         = 1'b0;
	assign o_irq_out_primary_oe      = irq_a_reg;
	assign o_irq_out_secondary       = 1'b0;
	assign o_irq_out_secondary_oe    = irq_b_reg;

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_quiet;
		!halt_reg && !osc_stop && !i_reg_wr.wr;
	endsequence
	sequence s_level_fall;
		##2 (o_irq_out_primary_oe && o_sec_inc);
	endsequence

	property p_spare_write;
		wr_b && !halt_reg && !osc_stop |=> spare_reg[0] == $past(wd[CB_SPAREA]);
	endproperty
	a_spare_write: assert property (p_spare_write) else $error("spare bit lost write");

	property p_off_high;
		ct_reg == CT_OFF && !alarm_flag_reg[1] |=> !o_irq_out_primary_oe;
	endproperty
	a_off_high: assert property (p_off_high) else $error("primary driven in off mode");

	property p_pulse_fall;
		s_quiet ##0 (ct_reg == CT_1HZ && q_reg == 2'h3 && qwrap && !i_sec_write) |=> ##1 o_irq_out_primary_oe;
	endproperty
	a_pulse_fall: assert property (p_pulse_fall) else $error("1 Hz pulse did not fall");

	property p_level_fall;
		s_quiet ##0 (sec_inc_w && ct_reg == CT_SEC) |-> s_level_fall;
	endproperty
	a_level_fall: assert property (p_level_fall) else $error("level not aligned to increment");

	property p_inc_delay;
		o_sec_inc && !$past(i_sec_write) && !$past(i_sec_write, 2) |-> q_reg == 2'h0 && qcnt_reg == SEC_DLY + 24'h1;
	endproperty
	a_inc_delay: assert property (p_inc_delay) else $error("increment delay wrong");

	property p_sec_write;
		i_sec_write |=> qcnt_reg == 24'h0 && q_reg == 2'h0;
	endproperty
	a_sec_write: assert property (p_sec_write) else $error("divider not cleared");

	property p_supply_low_flag_set;
		below_sel && !halt_reg && !osc_stop |=> supply_low_flag_reg;
	endproperty
	a_supply_low_flag_set: assert property (p_supply_low_flag_set) else $error("supply-low flag missed");

	property p_supply_low_flag_clr;
		supply_low_flag_reg && supply_low_flag_clr && !below_sel && !halt_reg |=> !supply_low_flag_reg;
	endproperty
	a_supply_low_flag_clr: assert property (p_supply_low_flag_clr) else $error("supply-low flag not cleared");

	property p_halt_set;
		osc_stop ##1 !halt_clr |-> halt_reg [*2];
	endproperty
	a_halt_set: assert property (p_halt_set) else $error("halt flag missed");

	property p_halt_quiet;
		halt_reg |=> !o_irq_out_primary_oe && !o_irq_out_secondary_oe && ct_reg == CT_OFF && adj_reg == ADJ_RST;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("halt did not stop outputs");

	property p_alarm_delay;
		g_alarm[0].fire && alarm_en_reg[0] && !halt_reg && !alarm_hit[0]
		|=> alarm_flag_reg[0] && alarm_dly_reg[0] == ALARM_DLY - 11'h1;
	endproperty
	a_alarm_delay: assert property (p_alarm_delay) else $error("alarm flag not set");

	property p_alarm_off;
		i_reg_raddr == ADDR_CTRL_B && !alarm_en_reg[1] |=> !o_reg_rdata[CB_WEEKLY_ALARM_FLAG];
	endproperty
	a_alarm_off: assert property (p_alarm_off) else $error("disabled alarm flag reads 1");

endmodule

// ---- rtccs_cal_model.sv ----
// Behavioural timekeeping counters and pin pull-ups beside the RTC core.
// Assumes the bench loads the counters with every seconds write.
`timescale 1ns/1ps

module rtccs_cal_model
	import rtccs_pkg::*;
(
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_nrst,
	// Counter control
	input  wire logic       i_sec_inc,
	input  wire logic       i_load,
	input  wire logic [5:0] i_sec,
	input  wire logic [5:0] i_min,
	input  wire logic [4:0] i_hour,
	input  wire logic [4:0] i_day,
	output rtccs_cal_t      o_cal_next,
	// Open-drain pins
	input  wire logic       i_pri_d,
	input  wire logic       i_pri_oe,
	input  wire logic       i_sec_d,
	input  wire logic       i_sec_oe,
	output logic            o_pri_n,
	output logic            o_sec_n
);
	logic [5:0] sec_reg;
	logic [5:0] min_reg;
	logic [4:0] hour_reg;
	logic [4:0] day_reg;

	// Carries of the coming increment
	wire c_s = (sec_reg == 6'h3b);
	wire c_m = c_s && (min_reg == 6'h3b);
	wire c_h = c_m && (hour_reg == 5'h17);

	// Calendar after the coming increment; months of 30 days
	assign o_cal_next.sec_zero  = c_s;
	assign o_cal_next.min_zero  = c_m || (min_reg == 6'h00 && !c_s);
	assign o_cal_next.hour_zero = c_h || (hour_reg == 5'h00 && !c_m);
	assign o_cal_next.day_one   = (c_h && day_reg == 5'h1e) || (day_reg == 5'h01 && !c_h);

	// Pull-ups on both interrupt lines
	assign o_pri_n = i_pri_oe ? i_pri_d : 1'b1;
	assign o_sec_n = i_sec_oe ? i_sec_d : 1'b1;

	// Counters advance on each seconds increment
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst || i_load) begin
			sec_reg  <= i_sec;
			min_reg  <= i_min;
			hour_reg <= i_hour;
			day_reg  <= i_day;
		end else if (i_sec_inc) begin
			sec_reg <= c_s ? 6'h00 : sec_reg + 6'h01;
			if (c_s) min_reg <= c_m ? 6'h00 : min_reg + 6'h01;
			if (c_m) hour_reg <= c_h ? 5'h00 : hour_reg + 5'h01;
			if (c_h) day_reg <= (day_reg == 5'h1e) ? 5'h01 : day_reg + 5'h01;
		end
	end
endmodule

// ---- rtccs_core_tb.sv ----
// Self-checking bench of the RTC control, status and interrupt core.
// Assumes a shortened quarter divider and the calendar model beside it.
`timescale 1ns/1ps

module rtccs_core_tb;
	import rtccs_pkg::*;
	localparam int QL = 2000;
	logic       i_ref_clk, i_nrst, i_sec_write, o_sec_inc;
	rtccs_wr_t  i_reg_wr;
	logic [3:0] i_reg_raddr;
	logic [7:0] o_reg_rdata;
	rtccs_cal_t i_cal_next;
	logic       i_weekly_alarm_match, i_daily_alarm_match;
	logic       i_osc_stopped, i_supply_below_2v1, i_supply_below_1v6;
	logic       o_hour24_mode, o_test_mode, o_supply_threshold_select;
	logic [6:0] o_adjust;
	logic       o_irq_out_primary, o_irq_out_primary_oe, o_irq_out_secondary, o_irq_out_secondary_oe;
	logic       pri_n, sec_n;
	logic [5:0] ld_sec, ld_min;
	logic [4:0] ld_hour, ld_day;
	int         miscompares, cmp_count, lows, rises, first_inc, n;

	// ********************************
	// Design and far side
	// ********************************
	rtccs_core #(.QUARTER_LEN(QL)) rtccs_core_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr),
		.i_reg_raddr(i_reg_raddr), .o_reg_rdata(o_reg_rdata), .i_sec_write(i_sec_write), .i_cal_next(i_cal_next),
		.i_weekly_alarm_match(i_weekly_alarm_match), .i_daily_alarm_match(i_daily_alarm_match),
		.o_sec_inc(o_sec_inc), .i_osc_stopped(i_osc_stopped), .i_supply_below_2v1(i_supply_below_2v1),
		.i_supply_below_1v6(i_supply_below_1v6), .o_hour24_mode(o_hour24_mode), .o_test_mode(o_test_mode),
		.o_adjust(o_adjust), .o_supply_threshold_select(o_supply_threshold_select),
		.o_irq_out_primary(o_irq_out_primary), .o_irq_out_primary_oe(o_irq_out_primary_oe),
		.o_irq_out_secondary(o_irq_out_secondary), .o_irq_out_secondary_oe(o_irq_out_secondary_oe));
	rtccs_cal_model rtccs_cal_model_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_sec_inc(o_sec_inc),
		.i_load(i_sec_write), .i_sec(ld_sec), .i_min(ld_min), .i_hour(ld_hour), .i_day(ld_day),
		.o_cal_next(i_cal_next), .i_pri_d(o_irq_out_primary), .i_pri_oe(o_irq_out_primary_oe),
		.i_sec_d(o_irq_out_secondary), .i_sec_oe(o_irq_out_secondary_oe), .o_pri_n(pri_n), .o_sec_n(sec_n));

	// ********************************
	// Tasks
	// ********************************
	// Compare a register byte
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t byte %h want %h", $time, got, exp);
		end
	endtask
	// Compare a pin or a condition
	task automatic chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t bit %b want %b", $time, got, exp);
		end
	endtask
	// One-cycle register write strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_reg_wr <= '{wr: 1'b1, addr: a, data: d};
		@(posedge i_ref_clk);
		i_reg_wr.wr <= 1'b0;
	endtask
	// Read a register and compare the masked bits
	task automatic rdm(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge i_ref_clk);
		i_reg_raddr <= a;
		repeat (2) @(posedge i_ref_clk);
		#1 chk8(o_reg_rdata & m, e);
	endtask
	// Pulse: 2 seconds write, 1 weekly match, 0 daily match
	task automatic pulse(input int k);
		@(posedge i_ref_clk);
		{i_sec_write, i_weekly_alarm_match, i_daily_alarm_match} <= 3'(1 << k);
		@(posedge i_ref_clk);
		{i_sec_write, i_weekly_alarm_match, i_daily_alarm_match} <= 3'h0;
	endtask
	// Cycles until an interrupt enable rises, bounded
	task automatic wait_pin(input logic sel);
		#1;
		for (n = 0; n < 2000; n++) begin
			if ((sel ? o_irq_out_secondary_oe : o_irq_out_primary_oe) === 1'b1) break;
			@(posedge i_ref_clk);
			#1;
		end
	endtask
	// Wait for the next seconds increment, bounded
	task automatic wait_inc();
		for (int c = 0; c < 9000; c++) begin
			@(posedge i_ref_clk);
			#1;
			if (o_sec_inc === 1'b1) break;
		end
	endtask
	// Low cycles, falls and first increment on the primary line
	task automatic measure(input int cyc);
		logic prv;
		prv = 1'b1;
		lows = 0;
		rises = 0;
		first_inc = 0;
		for (int i = 1; i <= cyc; i++) begin
			@(posedge i_ref_clk);
			#1;
			if (pri_n === 1'b0) lows++;
			if (pri_n === 1'b0 && prv === 1'b1) rises++;
			if (o_sec_inc === 1'b1 && first_inc == 0) first_inc = i;
			prv = pri_n;
		end
	endtask
	// Level mode: preload calendar, clear flag, check after one increment
	task automatic lvl(input logic [2:0] md, input logic [5:0] s, input logic [5:0] m, input logic [4:0] h,
		input logic [4:0] d, input logic e);
		wr(ADDR_CTRL_A, {5'h00, md});
		{ld_sec, ld_min, ld_hour, ld_day} <= {s, m, h, d};
		pulse(2);
		wr(ADDR_CTRL_B, 8'h00);
		wait_inc();
		chk1(o_irq_out_primary_oe, e);
	endtask
	// Counts and verdict
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ********************************
	// Clock, watchdog and tests
	// ********************************
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	// Cuts a hang short
	initial begin
		repeat (60000) @(posedge i_ref_clk);
		miscompares++;
		summarize();
	end
	// Control writes keep the factory test bit at 0 throughout
	initial begin
		{i_nrst, i_reg_wr, i_reg_raddr, i_sec_write, i_weekly_alarm_match, i_daily_alarm_match} <= '0;
		{i_osc_stopped, i_supply_below_2v1, i_supply_below_1v6} <= 3'h0;
		{ld_sec, ld_min, ld_hour, ld_day} <= '0;
		miscompares = 0;
		cmp_count = 0;
		repeat (4) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		rdm(ADDR_CTRL_B, 8'hff, CTRL_B_RST);
		wr(ADDR_CTRL_A, 8'hf7);
		rdm(ADDR_CTRL_A, 8'hff, 8'h00);
		rdm(ADDR_ADJUST, 8'hff, 8'h00);
		wr(ADDR_CTRL_B, 8'h00);
		rdm(ADDR_CTRL_B, 8'hff, 8'h00);
		wr(ADDR_CTRL_B, 8'h10);
		rdm(ADDR_CTRL_B, 8'hff, 8'h00);
		wr(4'h3, 8'hff);
		rdm(4'h3, 8'hff, 8'h00);
		// Spares, threshold and adjust, then a halt wipes them
		wr(ADDR_CTRL_A, 8'h11);
		wr(ADDR_CTRL_B, 8'ha8);
		wr(ADDR_ADJUST, 8'hc0);
		rdm(ADDR_CTRL_A, 8'hff, 8'h11);
		rdm(ADDR_CTRL_B, 8'hff, 8'hac);
		rdm(ADDR_ADJUST, 8'hff, 8'h40);
		chk1(o_supply_threshold_select, 1'b1);
		chk1(o_test_mode, 1'b0);
		@(posedge i_ref_clk) i_osc_stopped <= 1'b1;
		repeat (6) @(posedge i_ref_clk);
		i_osc_stopped <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		#1 chk1(o_irq_out_primary_oe, 1'b0);
		rdm(ADDR_CTRL_B, 8'hff, 8'h10);
		rdm(ADDR_CTRL_A, 8'hff, 8'h00);
		rdm(ADDR_ADJUST, 8'hff, 8'h00);
		wr(ADDR_CTRL_B, 8'h00);
		rdm(ADDR_CTRL_B, 8'hff, 8'h00);
		// Supply monitor at both thresholds; two sync flops plus the flag before a read
		@(posedge i_ref_clk) i_supply_below_2v1 <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		rdm(ADDR_CTRL_B, 8'h40, 8'h40);
		wr(ADDR_CTRL_B, 8'h00);
		rdm(ADDR_CTRL_B, 8'h40, 8'h40);
		@(posedge i_ref_clk) i_supply_below_2v1 <= 1'b0;
		repeat (5) @(posedge i_ref_clk);
		rdm(ADDR_CTRL_B, 8'h40, 8'h40);
		wr(ADDR_CTRL_B, 8'h40);
		rdm(ADDR_CTRL_B, 8'h40, 8'h40);
		wr(ADDR_CTRL_B, 8'h80);
		rdm(ADDR_CTRL_B, 8'hc0, 8'h80);
		@(posedge i_ref_clk) i_supply_below_2v1 <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		rdm(ADDR_CTRL_B, 8'hc0, 8'h80);
		@(posedge i_ref_clk) i_supply_below_1v6 <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		rdm(ADDR_CTRL_B, 8'hc0, 8'hc0);
		@(posedge i_ref_clk) {i_supply_below_2v1, i_supply_below_1v6} <= 2'h0;
		repeat (5) @(posedge i_ref_clk);
		wr(ADDR_CTRL_B, 8'h00);
		// Alarms: timing, clears, enables
		wr(ADDR_CTRL_A, 8'h80);
		pulse(1);
		wait_pin(1'b0);
		chk1(n >= ALARM_DELAY_CYC && n <= ALARM_DELAY_CYC + 3, 1'b1);
		rdm(ADDR_CTRL_B, 8'h02, 8'h02);
		wr(ADDR_CTRL_B, 8'h02);
		rdm(ADDR_CTRL_B, 8'h02, 8'h02);
		wr(ADDR_CTRL_B, 8'h00);
		rdm(ADDR_CTRL_B, 8'h02, 8'h00);
		chk1(pri_n, 1'b1);
		pulse(0);
		wait_pin(1'b1);
		chk1(o_irq_out_secondary_oe, 1'b0);
		rdm(ADDR_CTRL_B, 8'h01, 8'h00);
		wr(ADDR_CTRL_A, 8'h40);
		pulse(0);
		wait_pin(1'b1);
		chk1(n >= ALARM_DELAY_CYC && n <= ALARM_DELAY_CYC + 3, 1'b1);
		chk1(sec_n, 1'b0);
		wr(ADDR_CTRL_A, 8'h00);
		rdm(ADDR_CTRL_B, 8'h01, 8'h00);
		chk1(sec_n, 1'b1);
		// Periodic: off, held low, 2 Hz and 1 Hz
		measure(4000);
		chk8(8'(lows), 8'h00);
		wr(ADDR_CTRL_A, {5'h00, CT_LOW});
		measure(100);
		chk1(lows >= 97, 1'b1);
		rdm(ADDR_CTRL_B, 8'h04, 8'h04);
		for (int k = 2; k < 4; k++) begin
			wr(ADDR_CTRL_A, 8'(k));
			pulse(2);
			measure(4 * QL);
			chk1(lows >= 2 * QL - 2 && lows <= 2 * QL + 2, 1'b1);
			chk8(8'(rises), 8'(4 - k));
			chk1(first_inc >= SEC_DELAY_CYC && first_inc <= SEC_DELAY_CYC + 4, 1'b1);
		end
		measure(5 * QL / 2);
		chk1(pri_n, 1'b1);
		pulse(2);
		measure(4);
		chk1(lows > 0, 1'b1);
		// Level modes: every interval, near misses, flag clear
		lvl(CT_SEC, 6'h00, 6'h00, 5'h00, 5'h01, 1'b1);
		rdm(ADDR_CTRL_B, 8'h04, 8'h04);
		wr(ADDR_CTRL_B, 8'h00);
		// The clear reaches the pin driver one edge after the write lands
		repeat (2) @(posedge i_ref_clk);
		#1 chk1(o_irq_out_primary_oe, 1'b0);
		measure(1000);
		chk8(8'(lows), 8'h00);
		lvl(CT_MIN, 6'h3a, 6'h00, 5'h00, 5'h01, 1'b0);
		lvl(CT_MIN, 6'h3b, 6'h00, 5'h00, 5'h01, 1'b1);
		lvl(CT_HOUR, 6'h3b, 6'h3a, 5'h00, 5'h01, 1'b0);
		lvl(CT_HOUR, 6'h3b, 6'h3b, 5'h00, 5'h01, 1'b1);
		lvl(CT_MONTH, 6'h3b, 6'h3b, 5'h17, 5'h1d, 1'b0);
		lvl(CT_MONTH, 6'h3b, 6'h3b, 5'h17, 5'h1e, 1'b1);
		summarize();
	end
endmodule
